/* File: hdl/spimsp_buf2.v */
// spimsp_buf2.v: two-entry valid/ready buffer for received bytes
// assumes a single clock and an asynchronous active-high reset
module spimsp_buf2 #(
  parameter WIDTH = 8
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  assign o_in_ready = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else if (i_flush)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* File: hdl/spimsp_map.vh */
// spimsp_map.vh: register offsets, field positions, reset values, timing counts
// assumes an 8-bit special-function-register bus with 8-bit addresses
`ifndef SPIMSP_MAP_VH
`define SPIMSP_MAP_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SPIMSP_ADDR_IRQ_EN 8'hab
`define SPIMSP_ADDR_FLAGS 8'hb3
`define SPIMSP_ADDR_PWR 8'hbf
`define SPIMSP_ADDR_CTRL 8'hd1
`define SPIMSP_ADDR_DATA 8'hd2
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SPIMSP_IE_TX 3
`define SPIMSP_IE_RX 2
`define SPIMSP_IE_ERR 1
`define SPIMSP_FL_TXE 3
`define SPIMSP_FL_RXF 2
`define SPIMSP_FL_OVR 1
`define SPIMSP_FL_MODE_FAULT_FLAG 0
`define SPIMSP_PD_BIT 0
`define SPIMSP_CR_MODE_FAULT_ENABLE 6
`define SPIMSP_CR_MSTR 5
`define SPIMSP_CR_CLOCK_IDLE_LEVEL 4
`define SPIMSP_CR_CLOCK_PHASE_SELECT 3
// ---------------------------------------------------------------
// reset values and bits per byte
// ---------------------------------------------------------------
`define SPIMSP_RST_IRQ_EN 8'h00
`define SPIMSP_RST_PWR 8'h27
`define SPIMSP_RST_CTRL 7'h2c
`define SPIMSP_RST_IE 3'h0
`define SPIMSP_BITS_PER_BYTE 4'h8
`endif

/* File: hdl/spimsp_port.v */
// spimsp_port.v: four-wire serial port, master or slave, behind the special-function-register bus
// assumes bus strobes and serial pins are synchronous to i_mclk; slave clock well below i_mclk/4
//
// Contract
// R01: power-down bit zero enables the port; setting it partially resets the port.
// R02: tx empty flag sets on holding-to-shift move; interrupts when enabled.
// R03: rx full flag sets on shift-to-holding move; interrupts when enabled.
// R04: error enable gates both mode fault and overrun interrupts.
// R05: after reset tx empty reads one; other flags read zero.
// R06: writing the data port loads transmit holding and clears tx empty.
// R07: software writes data only while tx empty is high.
// R08: rx full clears on flag read with it set, then data read.
// R09: byte arriving while holding unread sets overrun, keeps old byte, drops new.
// R10: overrun clears on flag read with it set, then data read.
// R11: slave with fault enable: select rising mid-transfer sets mode fault.
// R12: master with fault enable: select low at any time sets mode fault.
// R13: mode fault clears on flag read with it set, then control write.
// R14: mode fault sets only when enabled; clearing enable keeps the flag.
// R15: select pin is general I/O only in enabled master without fault enable.
// R16: fault enable low: select ignored by master, only masks fault in slave.
// R17: master select one means master, zero slave; resets to one.
// R18: idle level fixes serial clock between transfers; both ends must match.
// R19: with phase zero the master raises select between bytes.
// R20: divisor codes give 2 to 256; bit rate clock/2/divisor; unused in slave.
// R21: data port writes go to tx holding, reads from separate rx holding.
// R22: partial reset sets tx empty, aborts, clears shifter and count, frees pins.
// R23: master data write starts transfer; empty shifter loads at once.
// R24: master mode fault sets power-down and tx empty, clears count, frees pins.
// R25: external master holds select low for the whole byte.
// R26: eight bits, msb first, one sampled and one driven per clock period.
module spimsp_port (
  input wire i_mclk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output wire o_irq,
  output wire o_pins_owned,
  output wire o_scs_owned,
  input wire i_sclk,
  output reg o_sclk,
  output wire o_sclk_oe,
  input wire i_mosi,
  output wire o_mosi,
  output wire o_mosi_oe,
  input wire i_miso,
  output wire o_miso,
  output wire o_miso_oe,
  input wire i_scs_n
);
`include "spimsp_map.vh"
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [7:0] pwr_reg;
  reg [2:0] ie_reg;
  reg [6:0] ctrl_reg;
  reg txe_reg, rxf_reg, ovr_reg, mode_fault_flag_reg;
  reg [7:0] txh_reg;
  reg [7:0] sh_reg;
  reg [3:0] bit_cnt_reg;
  reg busy_reg;
  reg [7:0] div_cnt_reg;
  reg half_reg;
  reg rx_arm_reg, ovr_arm_reg, mode_fault_flag_arm_reg;
  reg sclk_d_reg, scs_d_reg;
  reg in_bit_reg;

  wire pd = pwr_reg[`SPIMSP_PD_BIT];
  wire mstr = ctrl_reg[`SPIMSP_CR_MSTR];
  wire mode_fault_enable = ctrl_reg[`SPIMSP_CR_MODE_FAULT_ENABLE];
  wire clock_idle_level = ctrl_reg[`SPIMSP_CR_CLOCK_IDLE_LEVEL];
  wire clock_phase_select = ctrl_reg[`SPIMSP_CR_CLOCK_PHASE_SELECT];
  wire wr_data = i_wr && (i_addr == `SPIMSP_ADDR_DATA);
  wire rd_data = i_rd && (i_addr == `SPIMSP_ADDR_DATA);
  wire rd_flags = i_rd && (i_addr == `SPIMSP_ADDR_FLAGS);
  wire wr_ctrl = i_wr && (i_addr == `SPIMSP_ADDR_CTRL);

  // divisor 2..256 as half-period length 2^(code+1) clocks, gives clock/2/divisor per bit
  function [7:0] half_period;
    input [2:0] code;
    begin
      half_period = 8'hff >> (3'h7 - code);
    end
  endfunction

  // ---------------------------------------------------------------
  // pin ownership
  // ---------------------------------------------------------------
  assign o_pins_owned = ~pd; // [R22] [R24]
  assign o_scs_owned = ~pd && (~mstr || mode_fault_enable); // [R15] [R16]
  assign o_sclk_oe = ~pd && mstr;
  assign o_mosi_oe = ~pd && mstr;
  assign o_miso_oe = ~pd && ~mstr && ~i_scs_n;
  assign o_mosi = sh_reg[7]; // [R26]
  assign o_miso = sh_reg[7];

  // ---------------------------------------------------------------
  // receive buffer: two entries stand between shifter and holding register
  // ---------------------------------------------------------------
  reg rxb_valid_reg;
  reg [7:0] rxb_data_reg;
  wire rxb_in_ready, rxb_out_valid;
  wire [7:0] rxb_out_data;
  wire rxh_free = ~rxf_reg;
  spimsp_buf2 #(
    .WIDTH(8)
  ) u_rxbuf (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_flush(pd),
    .i_in_valid(rxb_valid_reg),
    .o_in_ready(rxb_in_ready),
    .i_in_data(rxb_data_reg),
    .o_out_valid(rxb_out_valid),
    .i_out_ready(rxh_free),
    .o_out_data(rxb_out_data)
  );
  reg [7:0] rxh_reg;
  wire rx_move = rxb_out_valid && rxh_free;
  wire rx_drop = rxf_reg || ovr_reg || rxb_valid_reg || rxb_out_valid;

  // ---------------------------------------------------------------
  // serial timing
  // ---------------------------------------------------------------
  wire sclk_in = clock_idle_level ^ i_sclk;
  wire s_lead = ~mstr && ~sclk_d_reg && sclk_in && ~i_scs_n;
  wire s_trail = ~mstr && sclk_d_reg && ~sclk_in && ~i_scs_n;
  wire tick = mstr && busy_reg && (div_cnt_reg == 8'h00);
  wire m_lead = tick && ~half_reg;
  wire m_trail = tick && half_reg;
  wire lead = m_lead || s_lead;
  wire trail = m_trail || s_trail;
  // phase 0 samples on the leading edge, phase 1 on the trailing one
  wire sample = clock_phase_select ? trail : lead;
  wire shift = clock_phase_select ? lead : trail;
  wire last = (bit_cnt_reg == `SPIMSP_BITS_PER_BYTE - 4'h1);
  wire byte_done = busy_reg && (clock_phase_select ? trail : shift) && last;
  wire m_fault = mstr && mode_fault_enable && ~i_scs_n && ~pd; // [R12] [R14]
  wire s_fault = ~mstr && mode_fault_enable && busy_reg && i_scs_n && ~scs_d_reg && ~pd; // [R11] [R14]
  wire load_m = mstr && ~busy_reg && ~txe_reg && ~pd; // [R23]
  wire s_start = ~mstr && scs_d_reg && ~i_scs_n;
  wire load_s = ~mstr && ~busy_reg && ~txe_reg && ~pd;

  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pwr_reg <= `SPIMSP_RST_PWR;
      ie_reg <= `SPIMSP_RST_IE;
      ctrl_reg <= `SPIMSP_RST_CTRL; // [R17]
      txe_reg <= 1'b1; // [R05]
      rxf_reg <= 1'b0;
      ovr_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      txh_reg <= 8'h00;
      rxh_reg <= 8'h00;
      sh_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      div_cnt_reg <= 8'h00;
      half_reg <= 1'b0;
      rx_arm_reg <= 1'b0;
      ovr_arm_reg <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      scs_d_reg <= 1'b1;
      in_bit_reg <= 1'b0;
      o_sclk <= 1'b0;
      rxb_valid_reg <= 1'b0;
      rxb_data_reg <= 8'h00;
    end
    else
    begin
      sclk_d_reg <= sclk_in;
      scs_d_reg <= i_scs_n;
      // built from the next half state so pin edges fall on the shift and sample ticks
      o_sclk <= clock_idle_level ^ (busy_reg && mstr && (half_reg ^ tick)); // [R18]
      if (rxb_in_ready)
      begin
        rxb_valid_reg <= 1'b0;
      end
      // bus writes
      if (i_wr && i_addr == `SPIMSP_ADDR_PWR)
      begin
        pwr_reg <= i_wdata; // [R01]
      end
      if (i_wr && i_addr == `SPIMSP_ADDR_IRQ_EN)
      begin
        ie_reg <= i_wdata[`SPIMSP_IE_TX:`SPIMSP_IE_ERR];
      end
      if (wr_ctrl)
      begin
        ctrl_reg <= i_wdata[6:0];
      end
      if (wr_data)
      begin
        txh_reg <= i_wdata; // [R21]
        txe_reg <= 1'b0; // [R06]
      end
      // flag read arms the clears; data read or control write completes them
      if (rd_flags)
      begin
        rx_arm_reg <= rxf_reg;
        ovr_arm_reg <= ovr_reg;
        mode_fault_flag_arm_reg <= mode_fault_flag_reg;
      end
      if (rd_data && rx_arm_reg)
      begin
        rxf_reg <= 1'b0; // [R08]
        rx_arm_reg <= 1'b0;
      end
      if (rd_data && ovr_arm_reg)
      begin
        ovr_reg <= 1'b0; // [R10]
        ovr_arm_reg <= 1'b0;
      end
      if (wr_ctrl && mode_fault_flag_arm_reg)
      begin
        mode_fault_flag_reg <= 1'b0; // [R13]
        mode_fault_flag_arm_reg <= 1'b0;
      end
      // shifter
      if (load_m || (load_s && s_start))
      begin
        sh_reg <= txh_reg;
        txe_reg <= 1'b1; // [R02]
        busy_reg <= 1'b1;
        bit_cnt_reg <= 4'h0;
        half_reg <= 1'b0;
        div_cnt_reg <= half_period(ctrl_reg[2:0]); // [R20]
      end
      else if (~mstr && s_start)
      begin
        busy_reg <= 1'b1;
        bit_cnt_reg <= 4'h0;
      end
      else if (busy_reg)
      begin
        if (mstr)
        begin
          div_cnt_reg <= (div_cnt_reg == 8'h00) ? half_period(ctrl_reg[2:0]) : div_cnt_reg - 8'h01;
          if (tick)
          begin
            half_reg <= ~half_reg;
          end
        end
        if (sample)
        begin
          in_bit_reg <= mstr ? i_miso : i_mosi;
        end
        // phase 1 keeps the msb through the first leading edge; phase 0 skips the last shift
        if (shift && (clock_phase_select ? (bit_cnt_reg != 4'h0) : ~last))
        begin
          sh_reg <= {sh_reg[6:0], in_bit_reg}; // [R26]
        end
        if (trail)
        begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (byte_done)
        begin
          busy_reg <= 1'b0;
          // an unread holding byte or a standing overrun drops the new byte
          if (rx_drop)
          begin
            ovr_reg <= 1'b1; // [R09]
          end
          else
          begin
            rxb_valid_reg <= 1'b1;
            rxb_data_reg <= clock_phase_select ? {sh_reg[6:0], (mstr ? i_miso : i_mosi)} : {sh_reg[6:0], in_bit_reg};
          end
        end
      end
      if (~mstr && busy_reg && i_scs_n && ~scs_d_reg)
      begin
        busy_reg <= 1'b0;
      end
      // receive holding register; once overrun, later bytes are dropped
      if (rx_move)
      begin
        rxh_reg <= rxb_out_data;
        rxf_reg <= 1'b1; // [R03]
      end
      if (m_fault || s_fault)
      begin
        mode_fault_flag_reg <= 1'b1;
      end
      if (m_fault)
      begin
        pwr_reg[`SPIMSP_PD_BIT] <= 1'b1; // [R24]
      end
      // partial reset; control bits and rx/overrun/fault flags survive it
      if (pd || m_fault)
      begin
        txe_reg <= 1'b1; // [R22]
        busy_reg <= 1'b0;
        sh_reg <= 8'h00;
        bit_cnt_reg <= 4'h0;
        half_reg <= 1'b0;
        rxb_valid_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt request and read mux
  // ---------------------------------------------------------------
  assign o_irq = (ie_reg[2] && txe_reg) || (ie_reg[1] && rxf_reg) ||
    (ie_reg[0] && (ovr_reg || mode_fault_flag_reg)); // [R02] [R03] [R04]

  always @*
  begin
    case (i_addr)
      `SPIMSP_ADDR_IRQ_EN: o_rdata = {4'h0, ie_reg, 1'b0};
      `SPIMSP_ADDR_FLAGS: o_rdata = {4'h0, txe_reg, rxf_reg, ovr_reg, mode_fault_flag_reg};
      `SPIMSP_ADDR_PWR: o_rdata = {1'b0, pwr_reg[6:0]};
      `SPIMSP_ADDR_CTRL: o_rdata = {1'b0, ctrl_reg};
      `SPIMSP_ADDR_DATA: o_rdata = rxh_reg; // [R21]
      default: o_rdata = 8'h00;
    endcase
  end
endmodule

/* File: verif/spimsp_monitor.sv */
// spimsp_monitor.sv: concurrent checks on the ports of spimsp_port
// assumes one clock, asynchronous active-high reset; bound to every spimsp_port
module spimsp_monitor (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_pins_owned,
  input wire logic o_scs_owned,
  input wire logic o_sclk_oe,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe,
  input wire logic i_scs_n
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // -----------------------------------------
  // shadow registers
  // -----------------------------------------
  logic [2:0] ie_reg;
  logic [6:0] ctrl_reg;
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      ie_reg <= 3'h0;
      ctrl_reg <= 7'h2c;
    end
    else if (i_wr && i_addr == 8'hab)
      ie_reg <= i_wdata[3:1];
    else if (i_wr && i_addr == 8'hd1)
      ctrl_reg <= i_wdata[6:0];
  sequence fault_seen;
    o_sclk_oe && ctrl_reg[6] && !i_scs_n;
  endsequence
  sequence ports_freed;
    !o_pins_owned && !o_sclk_oe && !o_mosi_oe;
  endsequence
  // -----------------------------------------
  // assertions
  // -----------------------------------------
  reset_quiet_a: assert property ($fell(i_rst) |-> !o_pins_owned && !o_irq && !o_sclk_oe)
    else $error("port active after reset");
  power_down_a: assert property (i_wr && i_addr == 8'hbf && i_wdata[0] |=> ports_freed)
    else $error("port still active after power down");
  power_up_a: assert property (i_wr && i_addr == 8'hbf && !i_wdata[0] |=> o_pins_owned)
    else $error("port not enabled");
  master_fault_a: assert property (fault_seen |-> ##[1:4] ports_freed)
    else $error("master fault did not free pins");
  slave_drive_a: assert property (o_miso_oe |-> o_pins_owned && !ctrl_reg[5])
    else $error("miso driven outside slave mode");
  master_drive_a: assert property (o_sclk_oe |-> o_mosi_oe && o_pins_owned && ctrl_reg[5])
    else $error("sclk driven outside master mode");
  irq_gate_a: assert property (ie_reg == 3'h0 |-> !o_irq)
    else $error("irq with all enables clear");
  select_pin_a: assert property (o_scs_owned == (o_pins_owned && (!ctrl_reg[5] || ctrl_reg[6])))
    else $error("select pin ownership wrong");
  unmapped_read_a: assert property (!(i_addr inside {8'hab, 8'hb3, 8'hbf, 8'hd1, 8'hd2}) |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind spimsp_port spimsp_monitor u_spimsp_monitor (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq), .o_pins_owned(o_pins_owned), .o_scs_owned(o_scs_owned),
  .o_sclk_oe(o_sclk_oe), .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe), .i_scs_n(i_scs_n));

/* File: verif/spimsp_slave_model.sv */
// spimsp_slave_model.sv: behavioural serial slave at the far side of the port
// assumes the bench sets the same idle level and phase as the port
module spimsp_slave_model (
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  input wire logic i_clock_idle_level,
  input wire logic i_clock_phase_select,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  int n = 0;
  initial o_miso = 1'b0;
  initial o_rx = 8'h00;
  // phase zero needs the first bit before the first edge
  always @(negedge i_sel_n)
  begin
    sh = i_tx;
    n = 0;
    if (!i_clock_phase_select) o_miso = sh[7];
  end
  // released line flips so a stale bit never reads as valid
  always @(posedge i_sel_n) o_miso = ~o_miso;
  always @(i_sclk)
    if (!i_sel_n && ((i_sclk ^ i_clock_idle_level) != i_clock_phase_select))
    begin
      o_rx = {o_rx[6:0], i_mosi};
      sh = {sh[6:0], 1'b0};
      n++;
      if (n == 8) sh = i_tx;
      if (n == 8) n = 0;
    end
    else if (!i_sel_n) o_miso = sh[7];
endmodule

/* File: verif/tb_spi_master_slave_port.sv */
// tb_spi_master_slave_port.sv: self-checking bench for spimsp_port with a serial slave model
// assumes the port, the slave model and the bound monitor are compiled first
module tb_spi_master_slave_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0, tb_sclk = 0, i_scs_n = 1, sel_n = 1, clock_idle_level = 0, clock_phase_select = 1;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, s_tx = 8'h00, v, tx;
  wire [7:0] o_rdata, s_rx;
  wire o_irq, o_pins_owned, o_scs_owned, o_sclk, o_sclk_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, m_miso;
  int bad_count = 0, total_checks = 0, cyc = 0, seed = 32'h5919, n, half;
  realtime t0;
  logic tb_mosi = 0;
  wire i_sclk = o_sclk_oe ? o_sclk : tb_sclk;
  wire i_mosi = o_mosi_oe ? o_mosi : tb_mosi;
  wire i_miso = o_miso_oe ? o_miso : m_miso;
  spimsp_port u_spimsp_port (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq), .o_pins_owned(o_pins_owned), .o_scs_owned(o_scs_owned),
    .i_sclk(i_sclk), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .i_mosi(i_mosi), .o_mosi(o_mosi),
    .o_mosi_oe(o_mosi_oe), .i_miso(i_miso), .o_miso(o_miso), .o_miso_oe(o_miso_oe), .i_scs_n(i_scs_n));
  spimsp_slave_model u_spimsp_slave_model (.i_sclk(i_sclk), .i_mosi(i_mosi), .i_sel_n(sel_n), .i_clock_idle_level(clock_idle_level),
    .i_clock_phase_select(clock_phase_select), .i_tx(s_tx), .o_miso(m_miso), .o_rx(s_rx));
  initial forever #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 60000) bad_count++;
    if (cyc == 60000) wrap_up();
  end
  // -----------------------------------------
  // shared tasks
  // -----------------------------------------
  function automatic int exp_half(input int code);
    return 2 << code;
  endfunction
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    if (got !== exp) bad_count++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    {i_addr, i_wdata, i_wr} = {a, d, 1'b1};
    @(negedge i_mclk);
    {i_addr, i_wr} = {8'h00, 1'b0};
  endtask
  // read data is combinational; it is taken at the rising edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    {i_addr, i_rd} = {a, 1'b1};
    @(posedge i_mclk);
    d = o_rdata;
    @(negedge i_mclk);
    {i_addr, i_rd} = {8'h00, 1'b0};
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    rd(a, v);
    check(nm, v, e);
  endtask
  task automatic xfer(input logic [7:0] d);
    @(negedge i_mclk);
    sel_n = 0;
    wr(8'hd2, d);
    @(o_sclk);
    t0 = $realtime;
    @(o_sclk);
    half = int'(($realtime - t0) / 8.0);
    {n, v} = 0;
    while (!v[2] && n < 3000)
    begin
      rd(8'hb3, v);
      n++;
    end
    @(negedge i_mclk);
    sel_n = 1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // -----------------------------------------
  // main sequence
  // -----------------------------------------
  initial
  begin
    repeat (20) @(negedge i_mclk);
    i_rst = 0;
    rc(8'hab, 8'h00, "ie");
    rc(8'hb3, 8'h08, "flags");
    rc(8'hbf, 8'h27, "pwr");
    rc(8'hd1, 8'h2c, "ctrl");
    rc(8'h7e, 8'h00, "unmapped");
    wr(8'hbf, 8'h00);
    wr(8'hab, 8'h08);
    check("txirq", o_irq, 1);
    wr(8'hab, 8'h04);
    $display("test 1 over");
    for (int i = 0; i < 8; i++)
    begin
      {clock_idle_level, clock_phase_select} = {i[0], i[1]};
      wr(8'hbf, 8'h01);
      wr(8'hd1, {3'h1, i[0], i[1], i[2:0]});
      wr(8'hbf, 8'h00);
      @(negedge i_mclk);
      check("idle", o_sclk, clock_idle_level);
      s_tx = 8'($random(seed));
      tx = 8'($random(seed));
      xfer(tx);
      check("flags", v, 8'h0c);
      check("rxirq", o_irq, 1);
      check("half", half, exp_half(i));
      check("sent", s_rx, tx);
      rc(8'hd2, s_tx, "recv");
      rc(8'hb3, 8'h08, "rxclr");
    end
    $display("test 2 over");
    wr(8'hbf, 8'h01);
    wr(8'hd1, 8'h28);
    wr(8'hbf, 8'h00);
    wr(8'hab, 8'h02);
    {clock_idle_level, clock_phase_select, s_tx} = {2'h1, 8'h5a};
    @(negedge i_mclk);
    sel_n = 0;
    wr(8'hd2, 8'($random(seed)));
    s_tx = 8'ha5;
    wr(8'hd2, 8'h3c);
    rc(8'hb3, 8'h00, "txfull");
    repeat (100) @(negedge i_mclk);
    rc(8'hb3, 8'h0e, "overrun");
    check("errirq", o_irq, 1);
    rc(8'hd2, 8'h5a, "kept");
    rd(8'hb3, v);
    check("ovrclr", v[1], 0);
    check("dropped", v[2], 0);
    rd(8'hd2, v);
    wr(8'hab, 8'h00);
    check("noirq", o_irq, 0);
    sel_n = 1;
    $display("test 3 over");
    wr(8'hbf, 8'h01);
    wr(8'hd1, 8'h60);
    wr(8'hbf, 8'h00);
    wr(8'hab, 8'h02);
    i_scs_n = 0;
    repeat (4) @(negedge i_mclk);
    i_scs_n = 1;
    rc(8'hbf, 8'h01, "faultpd");
    check("modirq", o_irq, 1);
    wr(8'hd1, 8'h20);
    rc(8'hb3, 8'h09, "fault");
    wr(8'hd1, 8'h20);
    rc(8'hb3, 8'h08, "faultclr");
    wr(8'hd1, 8'h48);
    wr(8'hbf, 8'h00);
    check("scs", o_scs_owned, 1);
    i_scs_n = 0;
    repeat (4) @(negedge i_mclk);
    tb_sclk = 1;
    repeat (8) @(negedge i_mclk);
    i_scs_n = 1;
    repeat (4) @(negedge i_mclk);
    tb_sclk = 0;
    check("slvon", o_pins_owned, 1);
    rc(8'hb3, 8'h09, "slvfault");
    wr(8'hd1, 8'h08);
    tx = 8'($random(seed));
    s_tx = 8'($random(seed));
    wr(8'hd2, tx);
    i_scs_n = 0;
    for (int b = 7; b >= 0; b--)
    begin
      repeat (4) @(negedge i_mclk);
      {tb_sclk, tb_mosi} = {1'b1, s_tx[b]};
      repeat (4) @(negedge i_mclk);
      v[b] = i_miso;
      tb_sclk = 0;
    end
    repeat (4) @(negedge i_mclk);
    i_scs_n = 1;
    check("slvsent", v, tx);
    rc(8'hb3, 8'h0c, "slvflags");
    rc(8'hd2, s_tx, "slvrecv");
    $display("test 4 over");
    wr(8'hd1, 8'h2f);
    @(negedge i_mclk);
    sel_n = 0;
    wr(8'hd2, tx);
    wr(8'hd2, tx);
    repeat (40) @(negedge i_mclk);
    wr(8'hbf, 8'h01);
    check("sclkoe", o_sclk_oe, 0);
    rc(8'hb3, 8'h08, "abort");
    sel_n = 1;
    $display("test 5 over");
    wrap_up();
  end
endmodule
